// ===== rtl/ccrb_params.svh
`ifndef CCRB_PARAMS_SVH
`define CCRB_PARAMS_SVH

// frame field positions
`define CCRB_TOP_MSB      15
`define CCRB_TOP_LSB      14
`define CCRB_RW_BIT       13
`define CCRB_ADDR_MSB     12
`define CCRB_ADDR_LSB     8
`define CCRB_DATA_MSB     7
`define CCRB_DATA_LSB     0

// register addresses
`define CCRB_ADDR_NOP     5'h00
`define CCRB_ADDR_C1      5'h01
`define CCRB_ADDR_C2      5'h02
`define CCRB_ADDR_C3      5'h03
`define CCRB_ADDR_C4      5'h04
`define CCRB_ADDR_C5      5'h05
`define CCRB_ADDR_C6      5'h06

// reset values
`define CCRB_RST_C1       8'h00
`define CCRB_RST_C2       8'h00
`define CCRB_RST_C3       8'h00
`define CCRB_RST_C4       8'h00
`define CCRB_RST_C5       8'h00
`define CCRB_RST_C6       8'h00

// writable bits; reserved and overflow bits stay zero in storage
`define CCRB_WMASK_C1     8'hef
`define CCRB_WMASK_C2     8'hfe
`define CCRB_WMASK_C3     8'hf7
`define CCRB_WMASK_C4     8'h7f
`define CCRB_WMASK_C5     8'hfe
`define CCRB_WMASK_C6     8'h80

// overflow flag position in control 2 and control 5
`define CCRB_OVF_BIT      0

// mute codes
`define CCRB_MON_MUTE     3'h0
`define CCRB_DRX_MUTE     3'h4
`define CCRB_DDAC_MUTE    3'h4
`define CCRB_VGAIN_MUTE   6'h30

`endif

// ===== rtl/ccrb_pkg.sv
`default_nettype none
package ccrb_pkg;
  typedef logic [15:0] ccrb_frame_t;
  typedef logic [4:0]  ccrb_addr_t;
  typedef logic [7:0]  ccrb_byte_t;
  typedef logic [5:0]  ccrb_vgain_t;
  typedef logic [2:0]  ccrb_gain3_t;
endpackage : ccrb_pkg
`default_nettype wire

// ===== rtl/ccrb_sync3.sv
`default_nettype none
module ccrb_sync3 #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // asynchronous level in, filtered level out
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  // three stage chain; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_out[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule : ccrb_sync3
`default_nettype wire

// ===== rtl/ccrb_top.sv
//
// Contract
// - frame bits 12..8 hold register address, bits 7..0 hold data
// - frame bit 13 low writes, high reads the addressed register
// - bits 15..14 zero; address 0 no operation; 1..6 select controls
// - control 1 bit 7 resets data channel; control 3 bit 7 voice
// - control 1 bit 6 powers down the data channel
// - control 1 bit 5 data loopback; bit 4 reserved, written zero
// - control 1 bit 3 picks monitor source: gain stage or DAC
// - control 1 bits 2..0 monitor gain, code 0 mutes
// - control 2 bits 7..5 data receive input gain, code 4 mutes
// - control 2 bits 4..2 data DAC attenuation, code 4 mutes
// - control 2 bit 1 enables monitor speaker driver, else muted
// - bit 0 of controls 2 and 5 reports ADC overflow
// - control 3 bit 6 powers down the voice channel
// - control 3 bits 5,4 voice loopbacks; bit 3 reserved zero
// - control 3 bit 2 selects microphone; bit 1 low selects handset
// - control 3 bit 0 mutes the line interface output buffer
// - control 4 bit 6 microphone preamp 20 dB; bit 7 reserved
// - control 4 bits 5..0 voice ADC gain, code 48 mutes
// - control 5 bits 7..2 voice DAC gain, same codes, 48 mutes
// - control 5 bit 1 enables headphone buffers, else muted
// - control 6 bit 7 mutes handset output; bits 6..0 reserved
`default_nettype none
`include "ccrb_params.svh"
module ccrb_top (
  // clock and reset
  input  wire logic                 REF_CLK,
  input  wire logic                 RST_B,
  // secondary frame in from the serial port logic
  input  wire logic                 FRAME_VALID,
  input  wire ccrb_pkg::ccrb_frame_t FRAME_WORD,
  // response frame out
  output var  logic                 RESP_VALID,
  output var  ccrb_pkg::ccrb_frame_t RESP_WORD,
  // overflow levels from the converters
  input  wire logic                 DATA_ADC_OVF,
  input  wire logic                 VOICE_ADC_OVF,
  // data channel controls
  output var  logic                 DATA_SW_RESET,
  output var  logic                 DATA_PWR_DOWN,
  output var  logic                 DATA_LOOPBACK,
  output var  logic                 MON_SRC_SEL,
  output var  ccrb_pkg::ccrb_gain3_t MON_GAIN,
  output var  ccrb_pkg::ccrb_gain3_t DATA_RX_GAIN,
  output var  ccrb_pkg::ccrb_gain3_t DATA_DAC_ATTEN,
  output var  logic                 MON_SPKR_EN,
  // voice channel controls
  output var  logic                 VOICE_SW_RESET,
  output var  logic                 VOICE_PWR_DOWN,
  output var  logic                 VOICE_LOOP_A,
  output var  logic                 VOICE_LOOP_B,
  output var  logic                 MIC_SEL,
  output var  logic                 HANDSET_SEL_B,
  output var  logic                 LINE_OUT_MUTE,
  output var  logic                 MIC_PREAMP_HI,
  output var  ccrb_pkg::ccrb_vgain_t VOICE_ADC_GAIN,
  output var  ccrb_pkg::ccrb_vgain_t VOICE_DAC_GAIN,
  output var  logic                 HP_SPKR_EN,
  output var  logic                 HANDSET_OUT_MUTE,
  // decoded mute states
  output var  logic                 MON_MUTE,
  output var  logic                 DATA_RX_MUTE,
  output var  logic                 DATA_DAC_MUTE,
  output var  logic                 VOICE_ADC_MUTE,
  output var  logic                 VOICE_DAC_MUTE
);
  import ccrb_pkg::*;

  ccrb_byte_t  ctl_ff [1:6];
  logic [1:0]  ovf_lvl;
  ccrb_addr_t  frm_addr;
  ccrb_byte_t  frm_data;
  logic        frm_read;
  logic        frm_ok;
  logic        addr_hit;
  logic        wr_hit;
  logic [2:0]  frm_idx;
  ccrb_byte_t  rd_data;
  logic        resp_valid_ff;
  ccrb_frame_t resp_word_ff;
  logic        mon_mute_ff;
  logic        drx_mute_ff;
  logic        ddac_mute_ff;
  logic        vadc_mute_ff;
  logic        vdac_mute_ff;

  // frame field split
  assign frm_addr = FRAME_WORD[`CCRB_ADDR_MSB:`CCRB_ADDR_LSB];
  assign frm_data = FRAME_WORD[`CCRB_DATA_MSB:`CCRB_DATA_LSB];
  assign frm_read = FRAME_WORD[`CCRB_RW_BIT];
  assign frm_ok   = FRAME_VALID &&
                    (FRAME_WORD[`CCRB_TOP_MSB:`CCRB_TOP_LSB] == 2'b00);
  assign addr_hit = (frm_addr >= `CCRB_ADDR_C1) &&
                    (frm_addr <= `CCRB_ADDR_C6);
  assign wr_hit   = frm_ok && !frm_read && addr_hit;
  assign frm_idx  = frm_addr[2:0];

  // writable bit mask per register
  function automatic ccrb_byte_t wmask(input logic [2:0] idx);
    ccrb_byte_t m;
    case (idx)
      3'h1:    m = `CCRB_WMASK_C1;
      3'h2:    m = `CCRB_WMASK_C2;
      3'h3:    m = `CCRB_WMASK_C3;
      3'h4:    m = `CCRB_WMASK_C4;
      3'h5:    m = `CCRB_WMASK_C5;
      3'h6:    m = `CCRB_WMASK_C6;
      default: m = 8'h00;
    endcase
    return m;
  endfunction : wmask

  // overflow levels pass the three stage filter
  ccrb_sync3 #(
    .WIDTH (2)
  ) u_ovf_sync (
    .clk       (REF_CLK),
    .rst_b     (RST_B),
    .async_in  ({VOICE_ADC_OVF, DATA_ADC_OVF}),
    .level_out (ovf_lvl)
  );

  // control register storage
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_ff[1] <= `CCRB_RST_C1;
      ctl_ff[2] <= `CCRB_RST_C2;
      ctl_ff[3] <= `CCRB_RST_C3;
      ctl_ff[4] <= `CCRB_RST_C4;
      ctl_ff[5] <= `CCRB_RST_C5;
      ctl_ff[6] <= `CCRB_RST_C6;
    end else if (wr_hit) begin
      ctl_ff[frm_idx] <= frm_data & wmask(frm_idx);
    end
  end

  // read mux with live overflow flags in bit 0
  always_comb begin
    case (frm_addr)
      `CCRB_ADDR_C1: rd_data = ctl_ff[1];
      `CCRB_ADDR_C2: rd_data = {ctl_ff[2][7:1], ovf_lvl[0]};
      `CCRB_ADDR_C3: rd_data = ctl_ff[3];
      `CCRB_ADDR_C4: rd_data = ctl_ff[4];
      `CCRB_ADDR_C5: rd_data = {ctl_ff[5][7:1], ovf_lvl[1]};
      `CCRB_ADDR_C6: rd_data = ctl_ff[6];
      default:       rd_data = 8'h00;     // no operation and unmapped
    endcase
  end

  // response frame one cycle after a read frame
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      resp_valid_ff <= 1'b0;
      resp_word_ff  <= 16'h0000;
    end else begin
      resp_valid_ff <= frm_ok && frm_read;
      if (frm_ok && frm_read) begin
        resp_word_ff <= {2'b00, 1'b1, frm_addr, rd_data};
      end
    end
  end

  assign RESP_VALID = resp_valid_ff;
  assign RESP_WORD  = resp_word_ff;

  // mute decodes, registered from the stored codes
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mon_mute_ff  <= 1'b1;
      drx_mute_ff  <= 1'b0;
      ddac_mute_ff <= 1'b0;
      vadc_mute_ff <= 1'b0;
      vdac_mute_ff <= 1'b0;
    end else begin
      mon_mute_ff  <= (ctl_ff[1][2:0] == `CCRB_MON_MUTE);
      drx_mute_ff  <= (ctl_ff[2][7:5] == `CCRB_DRX_MUTE);
      ddac_mute_ff <= (ctl_ff[2][4:2] == `CCRB_DDAC_MUTE);
      vadc_mute_ff <= (ctl_ff[4][5:0] == `CCRB_VGAIN_MUTE);
      vdac_mute_ff <= (ctl_ff[5][7:2] == `CCRB_VGAIN_MUTE);
    end
  end

  assign MON_MUTE       = mon_mute_ff;
  assign DATA_RX_MUTE   = drx_mute_ff;
  assign DATA_DAC_MUTE  = ddac_mute_ff;
  assign VOICE_ADC_MUTE = vadc_mute_ff;
  assign VOICE_DAC_MUTE = vdac_mute_ff;

  // data channel controls straight from stored bits
  assign DATA_SW_RESET  = ctl_ff[1][7];
  assign DATA_PWR_DOWN  = ctl_ff[1][6];
  assign DATA_LOOPBACK  = ctl_ff[1][5];
  assign MON_SRC_SEL    = ctl_ff[1][3];
  assign MON_GAIN       = ctl_ff[1][2:0];
  assign DATA_RX_GAIN   = ctl_ff[2][7:5];
  assign DATA_DAC_ATTEN = ctl_ff[2][4:2];
  assign MON_SPKR_EN    = ctl_ff[2][1];

  // voice channel controls straight from stored bits
  assign VOICE_SW_RESET   = ctl_ff[3][7];
  assign VOICE_PWR_DOWN   = ctl_ff[3][6];
  assign VOICE_LOOP_A     = ctl_ff[3][5];
  assign VOICE_LOOP_B     = ctl_ff[3][4];
  assign MIC_SEL          = ctl_ff[3][2];
  assign HANDSET_SEL_B    = ctl_ff[3][1];
  assign LINE_OUT_MUTE    = ctl_ff[3][0];
  assign MIC_PREAMP_HI    = ctl_ff[4][6];
  assign VOICE_ADC_GAIN   = ctl_ff[4][5:0];
  assign VOICE_DAC_GAIN   = ctl_ff[5][7:2];
  assign HP_SPKR_EN       = ctl_ff[5][1];
  assign HANDSET_OUT_MUTE = ctl_ff[6][7];

  // a write frame to control 1 lands its data field, masked to the writable bits, in that register
  frame_write_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    wr_hit && frm_addr == `CCRB_ADDR_C1 |=>
      ctl_ff[1] == ($past(frm_data) & `CCRB_WMASK_C1))
    else $error("control 1 did not take the written data");

  // a read frame leaves controls 1, 3 and 6 unchanged
  read_no_write_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    frm_ok && frm_read |=>
      $stable(ctl_ff[1]) && $stable(ctl_ff[3]) && $stable(ctl_ff[6]))
    else $error("read frame altered a register");

  // frames with a nonzero prefix get no response and leave controls 2 and 4 unchanged
  bad_prefix_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    FRAME_VALID && FRAME_WORD[15:14] != 2'b00 |=>
      !RESP_VALID && $stable(ctl_ff[2]) && $stable(ctl_ff[4]))
    else $error("frame with nonzero prefix was acted on");

  // a write to address zero leaves controls 1, 5 and 6 unchanged
  nop_write_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    frm_ok && !frm_read && frm_addr == `CCRB_ADDR_NOP |=>
      $stable(ctl_ff[1]) && $stable(ctl_ff[5]) && $stable(ctl_ff[6]))
    else $error("no operation address changed a register");

  // reserved and overflow storage bits stay clear
  reserved_zero_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    ctl_ff[1][4] == 1'b0 && ctl_ff[3][3] == 1'b0 &&
    ctl_ff[4][7] == 1'b0 && ctl_ff[6][6:0] == 7'h00 &&
    ctl_ff[2][0] == 1'b0 && ctl_ff[5][0] == 1'b0)
    else $error("reserved bit was stored");

  // read of control 2 answers with address and live overflow
  read_resp_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    frm_ok && frm_read && frm_addr == `CCRB_ADDR_C2 |=>
      RESP_VALID && RESP_WORD[12:8] == `CCRB_ADDR_C2 &&
      RESP_WORD[0] == $past(ovf_lvl[0]) &&
      RESP_WORD[7:1] == $past(ctl_ff[2][7:1]))
    else $error("control 2 read response is wrong");

  // overflow of the voice converter appears in control 5 reads
  voice_ovf_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    frm_ok && frm_read && frm_addr == `CCRB_ADDR_C5 |=>
      RESP_WORD[0] == $past(ovf_lvl[1]))
    else $error("voice overflow missing from response");

  // writing code 48 to the voice dac gain mutes two cycles later
  vdac_mute_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    wr_hit && frm_addr == `CCRB_ADDR_C5 &&
    frm_data[7:2] == `CCRB_VGAIN_MUTE |-> ##2 VOICE_DAC_MUTE)
    else $error("voice dac did not mute on code 48");

  // writing code 4 to the receive gain mutes two cycles later
  drx_mute_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    wr_hit && frm_addr == `CCRB_ADDR_C2 &&
    frm_data[7:5] == `CCRB_DRX_MUTE |-> ##2 DATA_RX_MUTE)
    else $error("receive gain did not mute on code 4");

  // after reset control 2 leaves gains at zero and speaker muted
  reg2_reset_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    $rose(RST_B) |-> DATA_RX_GAIN == 3'h0 && DATA_DAC_ATTEN == 3'h0 &&
      !MON_SPKR_EN)
    else $error("control 2 not clear after reset");

  // voice software reset and handset select bits follow a write of control 3
  voice_reset_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    wr_hit && frm_addr == `CCRB_ADDR_C3 |=>
      VOICE_SW_RESET == $past(frm_data[7]) &&
      HANDSET_SEL_B == $past(frm_data[1]))
    else $error("voice control bits did not follow the write");

  // control 1 write drives the data channel controls the next cycle
  data_ctl_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    wr_hit && frm_addr == `CCRB_ADDR_C1 |=>
      DATA_SW_RESET == $past(frm_data[7]) &&
      DATA_PWR_DOWN == $past(frm_data[6]) &&
      DATA_LOOPBACK == $past(frm_data[5]) &&
      MON_SRC_SEL == $past(frm_data[3]) &&
      MON_GAIN == $past(frm_data[2:0]))
    else $error("data channel controls did not follow the write");

  // control 2 write drives gains and the monitor speaker enable
  data_gain_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    wr_hit && frm_addr == `CCRB_ADDR_C2 |=>
      DATA_RX_GAIN == $past(frm_data[7:5]) &&
      DATA_DAC_ATTEN == $past(frm_data[4:2]) &&
      MON_SPKR_EN == $past(frm_data[1]))
    else $error("data channel gains did not follow the write");

  // control 3 write drives power down, loopbacks, source and mute
  voice_ctl_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    wr_hit && frm_addr == `CCRB_ADDR_C3 |=>
      VOICE_PWR_DOWN == $past(frm_data[6]) &&
      VOICE_LOOP_A == $past(frm_data[5]) &&
      VOICE_LOOP_B == $past(frm_data[4]) &&
      MIC_SEL == $past(frm_data[2]) &&
      LINE_OUT_MUTE == $past(frm_data[0]))
    else $error("voice channel controls did not follow the write");

  // control 4 write drives preamp gain and voice adc gain
  voice_in_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    wr_hit && frm_addr == `CCRB_ADDR_C4 |=>
      MIC_PREAMP_HI == $past(frm_data[6]) &&
      VOICE_ADC_GAIN == $past(frm_data[5:0]))
    else $error("voice input gains did not follow the write");

  // control 5 write drives voice dac gain and headphone enable
  voice_out_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    wr_hit && frm_addr == `CCRB_ADDR_C5 |=>
      VOICE_DAC_GAIN == $past(frm_data[7:2]) &&
      HP_SPKR_EN == $past(frm_data[1]))
    else $error("voice output gains did not follow the write");

  // mute flags track the stored codes one cycle behind
  mon_mute_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    MON_MUTE == ($past(MON_GAIN) == `CCRB_MON_MUTE))
    else $error("monitor mute flag does not match its code");

  ddac_mute_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    DATA_DAC_MUTE == ($past(DATA_DAC_ATTEN) == `CCRB_DDAC_MUTE))
    else $error("dac attenuation mute flag does not match its code");

  vadc_mute_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_B)
    VOICE_ADC_MUTE == ($past(VOICE_ADC_GAIN) == `CCRB_VGAIN_MUTE))
    else $error("voice adc mute flag does not match its code");
endmodule : ccrb_top
`default_nettype wire

// ===== test/ccrb_host_model.sv
`default_nettype none
module ccrb_host_model (
  // clock
  input  wire logic                  clk,
  // frame toward the register bank
  output var  logic                  frame_valid,
  output var  ccrb_pkg::ccrb_frame_t frame_word
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccrb_pkg::*;

  bit held;

  // idle at time zero
  initial begin
    frame_valid = 1'b0;
    frame_word  = 16'h0000;
  end

  // one frame, held one cycle; last=0 keeps valid up for back to back
  task automatic send(input logic [1:0] pfx, input logic rd,
                      input ccrb_addr_t addr, input ccrb_byte_t data,
                      input logic last);
    if (!held) begin
      @(posedge clk);
    end
    held = !last;
    frame_valid <= 1'b1;
    frame_word  <= {pfx, rd, addr, data};
    @(posedge clk);
    // released word shows its inverse so stale data cannot match
    if (last) begin
      frame_valid <= 1'b0;
      frame_word  <= ~{pfx, rd, addr, data};
    end
  endtask : send
endmodule : ccrb_host_model
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
`define CCRB_CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccrb_pkg::*;

  logic        ref_clk, rst_b, frame_valid, resp_valid, d_ovf, v_ovf;
  logic        d_rst, d_pd, d_lb, mon_src, mon_spk, v_rst, v_pd, v_la;
  logic        v_lb, mic, hs_b, line_m, mic_hi, hp_en, hs_m;
  ccrb_frame_t frame_word, resp_word;
  ccrb_gain3_t mon_g, rx_g, dac_a;
  ccrb_vgain_t vadc_g, vdac_g;
  wire  [4:0]  mutes;
  logic [7:0]  view [1:6];
  int          bad_count, comparisons;

  ccrb_top DUT (
    .REF_CLK(ref_clk), .RST_B(rst_b), .FRAME_VALID(frame_valid),
    .FRAME_WORD(frame_word), .RESP_VALID(resp_valid), .RESP_WORD(resp_word),
    .DATA_ADC_OVF(d_ovf), .VOICE_ADC_OVF(v_ovf), .DATA_SW_RESET(d_rst),
    .DATA_PWR_DOWN(d_pd), .DATA_LOOPBACK(d_lb), .MON_SRC_SEL(mon_src),
    .MON_GAIN(mon_g), .DATA_RX_GAIN(rx_g), .DATA_DAC_ATTEN(dac_a),
    .MON_SPKR_EN(mon_spk), .VOICE_SW_RESET(v_rst), .VOICE_PWR_DOWN(v_pd),
    .VOICE_LOOP_A(v_la), .VOICE_LOOP_B(v_lb), .MIC_SEL(mic),
    .HANDSET_SEL_B(hs_b), .LINE_OUT_MUTE(line_m), .MIC_PREAMP_HI(mic_hi),
    .VOICE_ADC_GAIN(vadc_g), .VOICE_DAC_GAIN(vdac_g), .HP_SPKR_EN(hp_en),
    .HANDSET_OUT_MUTE(hs_m), .MON_MUTE(mutes[4]), .DATA_RX_MUTE(mutes[3]),
    .DATA_DAC_MUTE(mutes[2]), .VOICE_ADC_MUTE(mutes[1]),
    .VOICE_DAC_MUTE(mutes[0]));

  ccrb_host_model HOST (.clk(ref_clk), .frame_valid(frame_valid),
                        .frame_word(frame_word));

  // control outputs gathered back into register layout
  assign view[1] = {d_rst, d_pd, d_lb, 1'b0, mon_src, mon_g};
  assign view[2] = {rx_g, dac_a, mon_spk, 1'b0};
  assign view[3] = {v_rst, v_pd, v_la, v_lb, 1'b0, mic, hs_b, line_m};
  assign view[4] = {1'b0, mic_hi, vadc_g};
  assign view[5] = {vdac_g, hp_en, 1'b0};
  assign view[6] = {hs_m, 7'h00};

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic wr(input ccrb_addr_t a, input ccrb_byte_t d);
    HOST.send(2'b00, 1'b0, a, d, 1'b1);
  endtask : wr

  // read, answer next cycle for one cycle only
  task automatic rd(input ccrb_addr_t a, input ccrb_byte_t exp);
    HOST.send(2'b00, 1'b1, a, 8'h00, 1'b1);
    #1;
    `CCRB_CHK(resp_valid, 1'b1)
    `CCRB_CHK(resp_word, {3'b001, a, exp})
    @(posedge ref_clk);
    #1;
    `CCRB_CHK(resp_valid, 1'b0)
  endtask : rd

  // reset, then every register reads zero
  task automatic t_reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    #1;
    for (int i = 1; i <= 6; i++) `CCRB_CHK(view[i], 8'h00)
    `CCRB_CHK(mutes, 5'b10000)
    @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int a = 1; a <= 6; a++) rd(a[4:0], 8'h00);
  endtask : t_reset

  // bad prefix, nop and unmapped addresses change nothing
  task automatic t_refused();
    ccrb_addr_t bad [3];
    bad = '{5'h00, 5'h07, 5'h1f};
    for (int p = 1; p < 4; p++) begin
      HOST.send(p[1:0], 1'b0, 5'h01, 8'hff, 1'b1);
      HOST.send(p[1:0], 1'b1, 5'h01, 8'h00, 1'b1);
      #1;
      `CCRB_CHK(resp_valid, 1'b0)
    end
    foreach (bad[i]) wr(bad[i], 8'hff);
    #1;
    for (int i = 1; i <= 6; i++) `CCRB_CHK(view[i], 8'h00)
    foreach (bad[i]) rd(bad[i], 8'h00);
  endtask : t_refused

  // mute decodes two edges after the write
  task automatic t_mute(input ccrb_addr_t a, input ccrb_byte_t d,
                        input logic [4:0] exp);
    wr(a, d);
    @(posedge ref_clk);
    #1;
    `CCRB_CHK(mutes, exp)
  endtask : t_mute

  // six writes back to back, then outputs and read back
  task automatic t_regs(input ccrb_byte_t pat);
    logic [7:0] m [1:6];
    m = '{8'hef, 8'hfe, 8'hf7, 8'h7f, 8'hfe, 8'h80};
    for (int a = 1; a <= 6; a++) begin
      HOST.send(2'b00, 1'b0, a[4:0], pat ^ a[7:0], a == 6);
    end
    #1;
    for (int a = 1; a <= 6; a++) begin
      `CCRB_CHK(view[a], (pat ^ a[7:0]) & m[a])
    end
    for (int a = 1; a <= 6; a++) begin
      rd(a[4:0], (pat ^ a[7:0]) & m[a]);
    end
    `CCRB_CHK(view[5][1], pat[1] ^ 1'b0)
  endtask : t_regs

  // write then read in the next cycle sees the new value
  task automatic t_b2b();
    HOST.send(2'b00, 1'b0, 5'h06, 8'h80, 1'b0);
    HOST.send(2'b00, 1'b1, 5'h06, 8'h00, 1'b1);
    #1;
    `CCRB_CHK(resp_valid, 1'b1)
    `CCRB_CHK(resp_word, {3'b001, 5'h06, 8'h80})
  endtask : t_b2b

  // overflow flags are live and cannot be written
  task automatic t_ovf();
    wr(5'h02, 8'h01);
    wr(5'h05, 8'h01);
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk);
      {d_ovf, v_ovf} <= k[1:0];
      repeat (6) @(posedge ref_clk);
      rd(5'h02, {7'h00, k[1]});
      rd(5'h05, {7'h00, k[0]});
    end
  endtask : t_ovf

  task automatic stop_test();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    d_ovf = 1'b0;
    v_ovf = 1'b0;
    t_reset();
    t_refused();
    t_mute(5'h01, 8'h05, 5'b00000);
    t_mute(5'h01, 8'h00, 5'b10000);
    t_mute(5'h02, 8'h90, 5'b11100);
    t_mute(5'h02, 8'h6c, 5'b10000);
    t_mute(5'h04, 8'h30, 5'b10010);
    t_mute(5'h04, 8'h21, 5'b10000);
    t_mute(5'h05, 8'hc0, 5'b10001);
    t_mute(5'h05, 8'h64, 5'b10000);
    t_regs(8'hff);
    t_regs(8'h5a);
    t_b2b();
    t_ovf();
    t_reset();
    stop_test();
  end
endmodule : tb
`default_nettype wire
